// ---- src/trig_frame_map.vh ----
// Constants for the trigger, framing and frame-store control block.
// Assumes a 25 MHz system clock and a plain address/strobe register port.
`ifndef TRIG_FRAME_MAP_VH
`define TRIG_FRAME_MAP_VH

`define CLK_HZ 25000000
`define MIN_ROW_RATE_HZ 66
`define MEM_BYTES 32'h07f00000
`define FRAME_CAP_MAX 11'h3e8

`define ADDR_CTRL 8'h00
`define ADDR_LAG 8'h04
`define ADDR_GEOM 8'h08
`define ADDR_PAYLOAD 8'h0c
`define ADDR_PERIOD 8'h10
`define ADDR_CMD 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_COUNTS 8'h1c
`define ADDR_CAP 8'h20

`define CTRL_SYNC 0
`define CTRL_SEL_LO 1
`define CTRL_SEL_HI 3
`define CTRL_BUF 4
`define CMD_BEGIN 0
`define CMD_STOP 1
`define CMD_CLR 2

`define SEL_BEGIN 3'h0
`define SEL_FINISH 3'h1
`define SEL_ROW 3'h2
`define SEL_IMAGE 3'h3

`define ROWS_MIN 13'h0001
`define ROWS_MAX 13'h1000
`define ROWS_RST 13'h0400
`define PERIOD_RST 32'h000061a8

`define KIND_NONE 3'h0
`define KIND_LEAD 3'h1
`define KIND_ROW 3'h2
`define KIND_TRAIL 3'h3
`define KIND_CHUNK 3'h4
`define KIND_ERR 3'h5

`endif

// ---- src/trigger_frame_output_control.v ----
// Trigger-driven acquisition, frame framing and frame-store release control.
// Pixel data travel elsewhere; this block emits packet descriptors that a
// stream packetiser turns into leader, row, trailer, chunk and error packets.
`timescale 1ns/100ps
`default_nettype none
`include "trig_frame_map.vh"

module trigger_frame_output_control #(
  parameter [31:0] ROW_PERIOD_MAX = `CLK_HZ / `MIN_ROW_RATE_HZ
) (
  input wire sys_clk,
  input wire rst,
  input wire trig_pin,
  input wire release_pin,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg out_valid,
  input wire out_ready,
  output reg [2:0] out_kind,
  output reg [15:0] out_frame,
  output reg [12:0] out_row
);
  wire live_tick;
  localparam [2:0] S_IDLE = 3'h0, S_SKIP = 3'h1, S_LEAD = 3'h2, S_ROWS = 3'h3,
    S_TRAIL = 3'h4, S_CHUNK = 3'h5, S_ERR = 3'h6;

  // Pin synchronisers: a level is taken once stages two and three agree
  wire [1:0] pin_in = {release_pin, trig_pin};
  reg [1:0] s1, s2, s3, lvl, lvl_d;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      always @(posedge sys_clk) begin
        if (rst) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          lvl[g] <= 1'b0;
          lvl_d[g] <= 1'b0;
        end else begin
          s1[g] <= pin_in[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g])
            lvl[g] <= s3[g];
          lvl_d[g] <= lvl[g];
        end
      end
    end
  endgenerate
  wire trig_edge = lvl[0] & ~lvl_d[0];
  wire rel_edge = lvl[1] & ~lvl_d[1];

  // Registers
  reg sync_en, buf_en;
  reg [2:0] sel;
  reg [15:0] row_lag_count;
  reg [11:0] top_row_skip;
  reg [12:0] rows_per_image;
  reg [31:0] image_byte_total, row_period;
  reg armed, acq, mismatch;
  reg [15:0] frame_trig_cnt, release_cnt;
  reg [10:0] capacity, stored, dropped;

  wire wr_cmd = reg_wr && reg_addr == `ADDR_CMD;
  wire cmd_begin = wr_cmd && reg_wdata[`CMD_BEGIN];
  wire cmd_stop = wr_cmd && reg_wdata[`CMD_STOP];
  wire cmd_clr = wr_cmd && reg_wdata[`CMD_CLR];
  wire [12:0] rows_wr = reg_wdata[28:16];
  wire [31:0] per_wr = reg_wdata;

  always @(posedge sys_clk) begin
    if (rst) begin
      sync_en <= 1'b0;
      buf_en <= 1'b0;
      sel <= `SEL_BEGIN;
      row_lag_count <= 16'h0000;
      top_row_skip <= 12'h000;
      rows_per_image <= `ROWS_RST;
      image_byte_total <= 32'h00000000;
      row_period <= `PERIOD_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_CTRL: begin
          sync_en <= reg_wdata[`CTRL_SYNC];
          sel <= reg_wdata[`CTRL_SEL_HI:`CTRL_SEL_LO];
          buf_en <= reg_wdata[`CTRL_BUF];
        end
        `ADDR_LAG: row_lag_count <= reg_wdata[15:0];
        `ADDR_GEOM: begin
          top_row_skip <= reg_wdata[11:0];
          if (rows_wr < `ROWS_MIN)
            rows_per_image <= `ROWS_MIN;
          else if (rows_wr > `ROWS_MAX)
            rows_per_image <= `ROWS_MAX;
          else
            rows_per_image <= rows_wr;
        end
        `ADDR_PAYLOAD: image_byte_total <= reg_wdata;
        `ADDR_PERIOD: begin
          // Clamped so the internal pace never drops below the lowest rate
          if (per_wr > ROW_PERIOD_MAX)
            row_period <= ROW_PERIOD_MAX;
          else if (per_wr == 32'h00000000)
            row_period <= 32'h00000001;
          else
            row_period <= per_wr;
        end
        default: ;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd) begin
      case (reg_addr)
        `ADDR_CTRL: reg_rdata <= {27'h0, buf_en, sel, sync_en};
        `ADDR_LAG: reg_rdata <= {16'h0, row_lag_count};
        `ADDR_GEOM: reg_rdata <= {3'h0, rows_per_image, 4'h0, top_row_skip};
        `ADDR_PAYLOAD: reg_rdata <= image_byte_total;
        `ADDR_PERIOD: reg_rdata <= row_period;
        `ADDR_STATUS: reg_rdata <= {5'h0, dropped, 2'h0, stored, mismatch, armed, acq};
        `ADDR_COUNTS: reg_rdata <= {release_cnt, frame_trig_cnt};
        `ADDR_CAP: reg_rdata <= {21'h0, capacity};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else
      reg_rdata <= 32'h00000000;
  end

  // Frame capacity by repeated subtraction after each payload write
  reg div_busy;
  reg [31:0] div_rem;
  reg [10:0] div_q;
  always @(posedge sys_clk) begin
    if (rst) begin
      div_busy <= 1'b0;
      div_rem <= 32'h00000000;
      div_q <= 11'h000;
      capacity <= `FRAME_CAP_MAX;
    end else if (reg_wr && reg_addr == `ADDR_PAYLOAD) begin
      div_busy <= 1'b1;
      div_rem <= `MEM_BYTES;
      div_q <= 11'h000;
    end else if (div_busy) begin
      if (image_byte_total == 32'h00000000) begin
        div_busy <= 1'b0;
        capacity <= `FRAME_CAP_MAX;
      end else if (div_rem >= image_byte_total && div_q <= `FRAME_CAP_MAX) begin
        div_rem <= div_rem - image_byte_total;
        div_q <= div_q + 11'h001;
      end else begin
        div_busy <= 1'b0;
        if (div_q == 11'h000)
          capacity <= 11'h000;
        else if (div_q - 11'h001 > `FRAME_CAP_MAX)
          capacity <= `FRAME_CAP_MAX;
        else
          capacity <= div_q - 11'h001;
      end
    end
  end

  // Acquisition control
  wire ext_trig = sync_en && armed && trig_edge;
  wire lag_on = !sync_en || sel == `SEL_BEGIN;
  wire live_on = (!sync_en || sel == `SEL_BEGIN || sel == `SEL_FINISH) ? acq : armed;
  wire ext_row = sync_en && sel == `SEL_ROW;
  reg [15:0] lag_left;
  always @(posedge sys_clk) begin
    if (rst) begin
      armed <= 1'b0;
      acq <= 1'b0;
      lag_left <= 16'h0000;
    end else if (cmd_stop) begin
      armed <= 1'b0;
      acq <= 1'b0;
    end else if (cmd_begin) begin
      if (sync_en) begin
        armed <= 1'b1;
        acq <= sel == `SEL_FINISH;
        lag_left <= 16'h0000;
      end else begin
        acq <= 1'b1;
        lag_left <= row_lag_count;
      end
    end else if (ext_trig && sel == `SEL_BEGIN && !acq) begin
      acq <= 1'b1;
      lag_left <= row_lag_count;
    end else if (ext_trig && sel == `SEL_FINISH) begin
      acq <= 1'b0;
    end else if (live_tick && lag_left != 16'h0000 && lag_on) begin
      lag_left <= lag_left - 16'h0001;
    end
  end

  // Line pacing: the trigger itself in single-row mode, else the divider
  reg [31:0] pace_cnt;
  wire pace_tick = pace_cnt + 32'h00000001 >= row_period;
  always @(posedge sys_clk) begin
    if (rst || !live_on || ext_row || pace_tick)
      pace_cnt <= 32'h00000000;
    else
      pace_cnt <= pace_cnt + 32'h00000001;
  end
  assign live_tick = live_on && (ext_row ? ext_trig : pace_tick);
  wire row_tick = live_tick && (lag_left == 16'h0000 || !lag_on);

  // Output slot: descriptors hold until the packetiser takes them
  wire slot_free = !out_valid || out_ready;

  // Live frame engine
  reg [2:0] st;
  reg [12:0] row_cnt;
  reg [15:0] frame_id;
  wire img_mode = sync_en && sel == `SEL_IMAGE;
  wire start = st == S_IDLE && (img_mode ? ext_trig : live_on);
  wire live_go = buf_en || slot_free;
  wire push = st == S_CHUNK && live_go && buf_en;
  always @(posedge sys_clk) begin
    if (rst) begin
      st <= S_IDLE;
      row_cnt <= 13'h0000;
      frame_id <= 16'h0000;
    end else begin
      case (st)
        S_IDLE: if (start) begin
          frame_id <= frame_id + 16'h0001;
          row_cnt <= 13'h0000;
          st <= (top_row_skip == 12'h000) ? S_LEAD : S_SKIP;
        end
        S_SKIP: if (row_tick) begin
          row_cnt <= row_cnt + 13'h0001;
          if (row_cnt + 13'h0001 == {1'b0, top_row_skip}) begin
            row_cnt <= 13'h0000;
            st <= S_LEAD;
          end
        end
        S_LEAD: if (live_go)
          st <= S_ROWS;
        S_ROWS: if (row_tick) begin
          row_cnt <= row_cnt + 13'h0001;
          if (row_cnt + 13'h0001 == rows_per_image)
            st <= S_TRAIL;
        end
        S_TRAIL: if (live_go)
          st <= S_CHUNK;
        S_CHUNK: if (live_go)
          st <= S_IDLE;
        default: st <= S_IDLE;
      endcase
      if (cmd_stop)
        st <= S_IDLE;
    end
  end

  // Frame store: identities of held frames, oldest first
  reg [15:0] fifo_mem [0:1023];
  reg [9:0] head, tail;
  reg [2:0] rst_st;
  reg [12:0] rrow;
  reg [15:0] rframe;
  wire rel = buf_en && rel_edge;
  wire rel_take = rel && rst_st == S_IDLE;
  wire pop = rel_take && dropped == 11'h000 && stored != 11'h000;
  wire full = stored >= capacity;
  always @(posedge sys_clk) begin
    if (push && capacity != 11'h000)
      fifo_mem[tail] <= frame_id;
  end
  always @(posedge sys_clk) begin
    if (rst) begin
      head <= 10'h000;
      tail <= 10'h000;
      stored <= 11'h000;
      dropped <= 11'h000;
    end else begin
      if (push && capacity == 11'h000)
        dropped <= dropped + 11'h001;
      else if (push) begin
        tail <= tail + 10'h001;
        if (full && !pop) begin
          head <= head + 10'h001;
          dropped <= dropped + 11'h001;
        end else if (!pop)
          stored <= stored + 11'h001;
      end
      if (pop)
        head <= head + 10'h001;
      if (pop && !push)
        stored <= stored - 11'h001;
      if (rel_take && dropped != 11'h000 && !push)
        dropped <= dropped - 11'h001;
    end
  end

  // Release engine replays a held frame, or an error for a dropped one
  always @(posedge sys_clk) begin
    if (rst) begin
      rst_st <= S_IDLE;
      rrow <= 13'h0000;
      rframe <= 16'h0000;
    end else begin
      case (rst_st)
        S_IDLE: if (rel_take && dropped != 11'h000)
          rst_st <= S_ERR;
        else if (pop) begin
          rframe <= fifo_mem[head];
          rrow <= 13'h0000;
          rst_st <= S_LEAD;
        end
        S_ERR: if (slot_free)
          rst_st <= S_IDLE;
        S_LEAD: if (slot_free)
          rst_st <= S_ROWS;
        S_ROWS: if (slot_free) begin
          rrow <= rrow + 13'h0001;
          if (rrow + 13'h0001 == rows_per_image)
            rst_st <= S_TRAIL;
        end
        S_TRAIL: if (slot_free)
          rst_st <= S_CHUNK;
        S_CHUNK: if (slot_free)
          rst_st <= S_IDLE;
        default: rst_st <= S_IDLE;
      endcase
    end
  end

  // Trigger bookkeeping
  always @(posedge sys_clk) begin
    if (rst) begin
      frame_trig_cnt <= 16'h0000;
      release_cnt <= 16'h0000;
      mismatch <= 1'b0;
    end else begin
      if (buf_en && ext_trig && img_mode)
        frame_trig_cnt <= frame_trig_cnt + 16'h0001;
      if (rel)
        release_cnt <= release_cnt + 16'h0001;
      // Set wins over a clear in the same cycle
      if (rel && (rst_st != S_IDLE || dropped != 11'h000 || stored == 11'h000))
        mismatch <= 1'b1;
      else if (cmd_clr)
        mismatch <= 1'b0;
    end
  end

  // Descriptor selection
  reg [2:0] next_kind;
  reg [15:0] next_frame;
  reg [12:0] next_row;
  always @* begin
    next_kind = `KIND_NONE;
    next_frame = frame_id;
    next_row = 13'h0000;
    if (!buf_en) begin
      case (st)
        S_LEAD: next_kind = `KIND_LEAD;
        S_ROWS: if (row_tick) begin
          next_kind = `KIND_ROW;
          next_row = row_cnt;
        end
        S_TRAIL: next_kind = `KIND_TRAIL;
        S_CHUNK: begin
          next_kind = `KIND_CHUNK;
          next_row = 13'h0000;
        end
        default: next_kind = `KIND_NONE;
      endcase
    end else begin
      next_frame = rframe;
      next_row = (rst_st == S_ROWS) ? rrow : 13'h0000;
      case (rst_st)
        S_ERR: next_kind = `KIND_ERR;
        S_LEAD: next_kind = `KIND_LEAD;
        S_ROWS: next_kind = `KIND_ROW;
        S_TRAIL: next_kind = `KIND_TRAIL;
        S_CHUNK: next_kind = `KIND_CHUNK;
        default: next_kind = `KIND_NONE;
      endcase
    end
  end

  // A live row met by a busy slot is lost: lines cannot be held back
  always @(posedge sys_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_kind <= `KIND_NONE;
      out_frame <= 16'h0000;
      out_row <= 13'h0000;
    end else if (slot_free) begin
      out_valid <= next_kind != `KIND_NONE;
      out_kind <= next_kind;
      out_frame <= next_frame;
      out_row <= next_row;
    end
  end
endmodule
`default_nettype wire

// ---- verif/gvsp_sink.sv ----
// Host-side model taking stream descriptors and logging them with timestamps.
// Assumes the descriptor handshake: taken on an edge with valid and ready.
`timescale 1ns/100ps
`default_nettype none
module gvsp_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic valid,
  input wire logic [2:0] kind,
  input wire logic [15:0] frame,
  input wire logic [12:0] row,
  output logic ready
);
  logic [2:0] kinds [$];
  logic [15:0] frames [$];
  logic [12:0] rows [$];
  int stamps [$];
  int cyc = 0;
  initial ready = 1'b1;
  // A slow host takes only one cycle in three
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ready <= !stall || (cyc % 3 == 0);
    if (!rst && valid && ready) begin
      kinds.push_back(kind);
      frames.push_back(frame);
      rows.push_back(row);
      stamps.push_back(cyc);
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_trigger_frame_output_control.sv ----
// Self-checking bench for the trigger, framing and frame-store block.
// Assumes the host sink model and the bound assertion monitor.
`timescale 1ns/100ps
`default_nettype none
`include "trig_frame_map.vh"
module tb_trigger_frame_output_control;
  logic sys_clk, rst, trig_pin, release_pin, reg_wr, reg_rd, out_valid, out_ready, stall;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [2:0] out_kind;
  logic [15:0] out_frame;
  logic [12:0] out_row;
  int num_errors = 0;
  int checks_done = 0;
  int base, t0;
  // Short period ceiling keeps line pacing quick in simulation
  trigger_frame_output_control #(.ROW_PERIOD_MAX(32'd100)) DUT (
    .sys_clk(sys_clk), .rst(rst), .trig_pin(trig_pin), .release_pin(release_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .out_valid(out_valid), .out_ready(out_ready),
    .out_kind(out_kind), .out_frame(out_frame), .out_row(out_row));
  gvsp_sink host (.clk(sys_clk), .rst(rst), .stall(stall), .valid(out_valid),
    .kind(out_kind), .frame(out_frame), .row(out_row), .ready(out_ready));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (exp !== got) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Pin levels held well past the three-flop synchroniser
  task automatic pulse(input bit rel);
    @(posedge sys_clk);
    if (rel) release_pin <= 1'b1;
    else trig_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    release_pin <= 1'b0;
    trig_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic wait_n(input int n);
    for (int i = 0; i < 5000 && host.kinds.size() < n; i++) @(posedge sys_clk);
    if (host.kinds.size() < n) begin
      check("descriptor count", n, host.kinds.size());
      give_verdict();
    end
  endtask
  task automatic frame_at(input int at, input int nrows);
    check("leader", `KIND_LEAD, host.kinds[at]);
    for (int r = 0; r < nrows; r++) begin
      check("row kind", `KIND_ROW, host.kinds[at + 1 + r]);
      check("row index", r, host.rows[at + 1 + r]);
    end
    check("trailer", `KIND_TRAIL, host.kinds[at + 1 + nrows]);
    check("chunk", `KIND_CHUNK, host.kinds[at + 2 + nrows]);
  endtask
  task automatic reset_defaults();
    rd_reg(`ADDR_GEOM);
    check("geometry", 32'h04000000, rd);
    rd_reg(`ADDR_PERIOD);
    check("period", `PERIOD_RST, rd);
    rd_reg(8'h24);
    check("unmapped", 32'h0, rd);
    wr(`ADDR_PERIOD, 32'd1000);
    rd_reg(`ADDR_PERIOD);
    check("period clamp", 32'd100, rd);
    repeat (1010) @(posedge sys_clk);
    rd_reg(`ADDR_CAP);
    check("capacity", `FRAME_CAP_MAX, rd);
  endtask
  task automatic single_frames();
    wr(`ADDR_CTRL, 32'h7);
    wr(`ADDR_GEOM, 32'h00030003);
    wr(`ADDR_PERIOD, 32'd10);
    base = host.kinds.size();
    pulse(0);
    repeat (200) @(posedge sys_clk);
    check("unarmed output", base, host.kinds.size());
    wr(`ADDR_CMD, 32'h1);
    for (int k = 0; k < 2; k++) begin
      stall <= k[0];
      t0 = host.cyc;
      pulse(0);
      pulse(0);
      wait_n(base + 6 * (k + 1));
      check("skip lines", 1, host.stamps[base + 6 * k] - t0 >= 20);
      frame_at(base + 6 * k, 3);
      repeat (300) @(posedge sys_clk);
      check("quiet after frame", base + 6 * (k + 1), host.kinds.size());
    end
    stall <= 1'b0;
  endtask
  task automatic single_rows();
    // No top skip and a tall image so every trigger yields a row
    wr(`ADDR_GEOM, 32'h10000000);
    wr(`ADDR_LAG, 32'd5);
    wr(`ADDR_CTRL, 32'h5);
    wr(`ADDR_CMD, 32'h1);
    repeat (5) @(posedge sys_clk);
    base = host.kinds.size();
    repeat (3) pulse(0);
    repeat (50) @(posedge sys_clk);
    check("rows per trigger", base + 3, host.kinds.size());
    check("unmasked row", `KIND_ROW, host.kinds[base]);
    wr(`ADDR_CMD, 32'h2);
  endtask
  task automatic lag_start(input logic [31:0] ctrl);
    wr(`ADDR_LAG, 32'd4);
    wr(`ADDR_GEOM, 32'h00030000);
    wr(`ADDR_CTRL, ctrl);
    base = host.kinds.size();
    t0 = host.cyc;
    wr(`ADDR_CMD, 32'h1);
    if (ctrl[0]) pulse(0);
    wait_n(base + 2);
    check("first masked row", `KIND_ROW, host.kinds[base + 1]);
    check("output after lag", 1, host.stamps[base + 1] - t0 >= 30);
    rd_reg(`ADDR_STATUS);
    check("acquiring", 1, rd[0]);
    wr(`ADDR_CTRL, ctrl | 32'h2);
    if (ctrl[0]) pulse(0);
    else wr(`ADDR_CMD, 32'h2);
    repeat (100) @(posedge sys_clk);
    rd_reg(`ADDR_STATUS);
    check("stopped", 0, rd[0]);
    base = host.kinds.size();
    repeat (200) @(posedge sys_clk);
    check("quiet after stop", base, host.kinds.size());
    wr(`ADDR_CMD, 32'h2);
  endtask
  task automatic buffered();
    wr(`ADDR_PAYLOAD, 32'h02a55555);
    wr(`ADDR_CTRL, 32'h17);
    wr(`ADDR_CMD, 32'h1);
    repeat (1010) @(posedge sys_clk);
    rd_reg(`ADDR_CAP);
    check("capacity", 32'd2, rd);
    base = host.kinds.size();
    repeat (4) begin
      pulse(0);
      repeat (100) @(posedge sys_clk);
    end
    check("held frames", base, host.kinds.size());
    rd_reg(`ADDR_STATUS);
    check("stored and dropped", 32'h00020010, rd & 32'hfffffff8);
    rd_reg(`ADDR_COUNTS);
    check("begin count", 32'd4, rd[15:0]);
    for (int k = 0; k < 4; k++) begin
      pulse(1);
      wait_n(base + (k < 2 ? k + 1 : 2 + 6 * (k - 1)));
    end
    check("error first", `KIND_ERR, host.kinds[base]);
    check("error second", `KIND_ERR, host.kinds[base + 1]);
    frame_at(base + 2, 3);
    frame_at(base + 8, 3);
    check("oldest first", 1, host.frames[base + 2] < host.frames[base + 8]);
    pulse(1);
    repeat (50) @(posedge sys_clk);
    rd_reg(`ADDR_STATUS);
    check("mismatch set", 1, rd[2]);
    wr(`ADDR_CMD, 32'h4);
    rd_reg(`ADDR_STATUS);
    check("mismatch clear", 0, rd[2]);
    rd_reg(`ADDR_COUNTS);
    check("release count", 32'd5, rd[31:16]);
  endtask
  initial begin
    rst = 1'b1;
    trig_pin = 1'b0;
    release_pin = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    stall = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    reset_defaults();
    single_frames();
    single_rows();
    lag_start(32'h1);
    lag_start(32'h0);
    buffered();
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- verif/trig_monitor.sv ----
// Assertions on the control block's register port and descriptor stream.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "trig_frame_map.vh"
module trig_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic trig_pin,
  input wire logic release_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [2:0] out_kind,
  input wire logic [15:0] out_frame,
  input wire logic [12:0] out_row
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  cmd_read_a: assert property ($past(reg_rd) && $past(reg_addr) == `ADDR_CMD |-> reg_rdata == 0)
    else $error("command register read not zero");
  unmapped_read_a: assert property ($past(reg_rd) && $past(reg_addr) > `ADDR_CAP |-> !reg_rdata)
    else $error("unmapped read not zero");
  desc_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_kind) && $stable(out_row)
      && $stable(out_frame))
    else $error("descriptor changed before acceptance");
  kind_legal_a: assert property (out_valid |-> out_kind inside {[1:5]})
    else $error("illegal descriptor kind");
  row_zero_a: assert property (out_valid && out_kind != `KIND_ROW |-> out_row == 0)
    else $error("non-row descriptor with row index");
  row_bound_a: assert property (out_valid && out_kind == `KIND_ROW |-> out_row < `ROWS_MAX)
    else $error("row index beyond image");
  chunk_follow_a: assert property (
    out_valid && out_ready && out_kind == `KIND_TRAIL |=> ##[0:4] out_valid
      && out_kind == `KIND_CHUNK)
    else $error("no chunk after trailer");
  cover property (out_valid && out_ready && out_kind == `KIND_LEAD);
  cover property (out_valid && out_ready && out_kind == `KIND_ERR);
  cover property (out_valid && !out_ready);
endmodule
bind trigger_frame_output_control trig_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
  .trig_pin(trig_pin), .release_pin(release_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_valid(out_valid),
  .out_ready(out_ready), .out_kind(out_kind), .out_frame(out_frame), .out_row(out_row));
`default_nettype wire
